// ---- rtl/pgm_regs.svh ----
// register offsets, field positions and reset values of the supply-ok monitor
`ifndef PGM_REGS_SVH
`define PGM_REGS_SVH

`define PGM_ADDR_SRC_CTRL 8'h15
`define PGM_ADDR_MODE_CTRL 8'h16
`define PGM_ADDR_FAULT 8'h17
`define PGM_ADDR_SOFT_RESET 8'h18
`define PGM_ADDR_EVT_TOP 8'h19
`define PGM_ADDR_EVT_RESET 8'h1A

`define PGM_BIT_POLARITY 7
`define PGM_BIT_DRIVER_TYPE 6
`define PGM_BIT_LINEAR_WINDOW 5
`define PGM_BIT_STEPDOWN_WINDOW 4
`define PGM_BIT_MON_THERMAL 2
`define PGM_BIT_FAULT_SELECT 1
`define PGM_BIT_OP_MODE 0
`define PGM_BIT_SOFT_RESET 0
`define PGM_BIT_SUPPLY_LOST 7
`define PGM_BIT_RESET_EVENT 0

`define PGM_SRC_CTRL_RST 8'h7F
`define PGM_MODE_CTRL_RST 3'h4
`define PGM_MODE_WIDTH 3
`define PGM_NUM_SRC 4
`define PGM_FIRST_LINEAR 2
`define PGM_SYNC_STAGES 2

`endif

// ---- rtl/pgm_pkg.sv ----
// types shared by the supply-ok monitor files
package pgm_pkg;
	typedef logic [7:0] pgm_byte_t;
	typedef logic [3:0] pgm_src_t;
	typedef enum logic [1:0] {
		PGM_DRV_PUSH_PULL = 2'b01,
		PGM_DRV_OPEN_DRAIN = 2'b10
	} pgm_drv_t;
endpackage : pgm_pkg

// ---- rtl/pgm_sync.sv ----
// multi-stage synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module pgm_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] stage_r [STAGES];

	generate
		if (STAGES < 2 || WIDTH < 1) begin : g_bad_param
			$error("pgm_sync needs at least two stages and one bit");
		end
	endgenerate

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int k = 0; k < STAGES; k++) begin
				stage_r[k] <= '0;
			end
		end else begin
			stage_r[0] <= i_d;
			for (int k = 1; k < STAGES; k++) begin
				stage_r[k] <= stage_r[k-1];
			end
		end
	end

	assign o_q = stage_r[STAGES-1];
endmodule : pgm_sync

// ---- rtl/pgm_supply_ok_monitor.sv ----
// supply-ok monitor: source combining, fault flags, soft reset and their registers
// Functional notes
// - polarity bit 7: 0 pin high when valid, 1 pin low when valid
// - driver bit 6: 0 push-pull, 1 open-drain; resets to 1
// - bit 5: linear outputs checked undervoltage only, or both over and under
// - bit 4: step-down outputs checked undervoltage only, or both over and under
// - bits 3..0 enable each source into supply ok; all reset to 1
// - mode register bit 2 lets an active thermal warning force supply ok inactive
// - mode bit 1: output follows live validity, or the fault flags
// - mode bit 0 picks gated or continuous operation; resets to 0
// - fault flag set when its monitored source goes invalid; flags reset to 0
// - writing 1 clears a fault flag only while that source is valid
// - writing 1 to soft reset restores defaults, reloads settings, resets serial port
// - the soft reset bit clears itself after the reset it commands
// - soft reset request sets a latched reset-occurred flag, write 1 clears
// - supply ok falling from active to inactive sets a latched flag, write 1 clears
`timescale 1ns/1ps
`include "pgm_regs.svh"
module pgm_supply_ok_monitor import pgm_pkg::*; #(
	parameter int SYNC_STAGES = `PGM_SYNC_STAGES
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [3:0] i_undervoltage,
	input wire logic [3:0] i_overvoltage,
	input wire logic i_thermal_warning,
	input wire logic [3:0] i_regulator_enabled,
	output logic [7:0] o_reg_rdata,
	output logic o_supply_ok_output,
	output logic o_supply_ok_oe,
	output logic o_supply_ok_active,
	output logic o_otp_reload,
	output logic o_serial_if_reset
);
	generate
		if (SYNC_STAGES < 2) begin : g_bad_param
			$error("SYNC_STAGES must be at least 2");
		end
	endgenerate

	logic rst_n;
	logic [8:0] analog_s;
	pgm_src_t uv_s;
	pgm_src_t ov_s;
	logic twarn_s;

	pgm_sync #(.WIDTH(1), .STAGES(2)) u_rst_sync (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_d(1'b1),
		.o_q(rst_n)
	);

	pgm_sync #(.WIDTH(9), .STAGES(SYNC_STAGES)) u_in_sync (
		.i_sys_clk(i_sys_clk),
		.i_nrst(rst_n),
		.i_d({i_thermal_warning, i_overvoltage, i_undervoltage}),
		.o_q(analog_s)
	);

	assign uv_s = analog_s[3:0];
	assign ov_s = analog_s[7:4];
	assign twarn_s = analog_s[8];

	// per-source validity under the selected window checks
	function automatic pgm_src_t src_valid(input pgm_src_t uv, input pgm_src_t ov, input logic lwin,
		input logic swin);
		pgm_src_t v;
		logic win;
		v = '0;
		for (int i = 0; i < `PGM_NUM_SRC; i++) begin
			win = (i >= `PGM_FIRST_LINEAR) ? lwin : swin;
			v[i] = !uv[i] && !(win && ov[i]);
		end
		return v;
	endfunction : src_valid

	pgm_byte_t src_ctrl_r, src_ctrl_nxt;
	logic [`PGM_MODE_WIDTH-1:0] mode_r, mode_nxt;
	pgm_src_t fault_r, fault_nxt;
	logic soft_reset_r, soft_reset_nxt;
	logic lost_r, lost_nxt;
	logic rst_evt_r, rst_evt_nxt;
	logic active_r, active_nxt;
	pgm_byte_t rdata_r, rdata_nxt;

	pgm_src_t valid;
	pgm_src_t monitored;
	pgm_src_t fault_set;
	pgm_src_t fault_clr;
	pgm_src_t clear_blocked;
	logic live_ok;
	logic source_ok;
	logic wr_src, wr_mode, wr_fault, wr_soft, wr_top, wr_rst_evt;
	logic pin_level;
	pgm_drv_t drv;

	always_comb begin
		wr_src = i_reg_wr && (i_reg_addr == `PGM_ADDR_SRC_CTRL);
		wr_mode = i_reg_wr && (i_reg_addr == `PGM_ADDR_MODE_CTRL);
		wr_fault = i_reg_wr && (i_reg_addr == `PGM_ADDR_FAULT);
		wr_soft = i_reg_wr && (i_reg_addr == `PGM_ADDR_SOFT_RESET);
		wr_top = i_reg_wr && (i_reg_addr == `PGM_ADDR_EVT_TOP);
		wr_rst_evt = i_reg_wr && (i_reg_addr == `PGM_ADDR_EVT_RESET);

		valid = src_valid(uv_s, ov_s, src_ctrl_r[`PGM_BIT_LINEAR_WINDOW],
			src_ctrl_r[`PGM_BIT_STEPDOWN_WINDOW]);
		// gated mode ignores sources whose regulator is switched off
		monitored = src_ctrl_r[3:0] & (mode_r[`PGM_BIT_OP_MODE] ? 4'hF : i_regulator_enabled);
		live_ok = &(valid | ~monitored);
		source_ok = mode_r[`PGM_BIT_FAULT_SELECT] ? (fault_r == 4'h0) : live_ok;
		active_nxt = source_ok && !(mode_r[`PGM_BIT_MON_THERMAL] && twarn_s);

		fault_set = monitored & ~valid;
		clear_blocked = (wr_fault && !soft_reset_r) ? (i_reg_wdata[3:0] & ~valid) : 4'h0;
		fault_clr = (wr_fault && !soft_reset_r) ? (i_reg_wdata[3:0] & valid) : 4'h0;

		src_ctrl_nxt = src_ctrl_r;
		mode_nxt = mode_r;
		fault_nxt = (fault_r & ~fault_clr) | fault_set;
		soft_reset_nxt = soft_reset_r;
		lost_nxt = lost_r;
		rst_evt_nxt = rst_evt_r;

		if (soft_reset_r) begin
			// writes in the reset cycle are dropped; new events still land
			src_ctrl_nxt = `PGM_SRC_CTRL_RST;
			mode_nxt = `PGM_MODE_CTRL_RST;
			fault_nxt = fault_set;
			soft_reset_nxt = 1'b0;
			lost_nxt = 1'b0;
			rst_evt_nxt = 1'b1;
		end else begin
			if (wr_src) begin
				src_ctrl_nxt = i_reg_wdata;
			end
			if (wr_mode) begin
				mode_nxt = i_reg_wdata[`PGM_MODE_WIDTH-1:0];
			end
			if (wr_soft && i_reg_wdata[`PGM_BIT_SOFT_RESET]) begin
				soft_reset_nxt = 1'b1;
			end
			if (wr_top && i_reg_wdata[`PGM_BIT_SUPPLY_LOST]) begin
				lost_nxt = 1'b0;
			end
			if (wr_rst_evt && i_reg_wdata[`PGM_BIT_RESET_EVENT]) begin
				rst_evt_nxt = 1'b0;
			end
		end
		if (active_r && !active_nxt) begin
			lost_nxt = 1'b1;
		end

		rdata_nxt = rdata_r;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`PGM_ADDR_SRC_CTRL: rdata_nxt = src_ctrl_r;
				`PGM_ADDR_MODE_CTRL: rdata_nxt = {5'h00, mode_r};
				`PGM_ADDR_FAULT: rdata_nxt = {4'h0, fault_r};
				`PGM_ADDR_SOFT_RESET: rdata_nxt = {7'h00, soft_reset_r};
				`PGM_ADDR_EVT_TOP: rdata_nxt = {lost_r, 7'h00};
				`PGM_ADDR_EVT_RESET: rdata_nxt = {7'h00, rst_evt_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_ctrl_r <= `PGM_SRC_CTRL_RST;
			mode_r <= `PGM_MODE_CTRL_RST;
			fault_r <= 4'h0;
			soft_reset_r <= 1'b0;
			lost_r <= 1'b0;
			rst_evt_r <= 1'b0;
			active_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			src_ctrl_r <= src_ctrl_nxt;
			mode_r <= mode_nxt;
			fault_r <= fault_nxt;
			soft_reset_r <= soft_reset_nxt;
			lost_r <= lost_nxt;
			rst_evt_r <= rst_evt_nxt;
			active_r <= active_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// pin drive from the registered active state
	always_comb begin
		drv = src_ctrl_r[`PGM_BIT_DRIVER_TYPE] ? PGM_DRV_OPEN_DRAIN : PGM_DRV_PUSH_PULL;
		pin_level = active_r ^ src_ctrl_r[`PGM_BIT_POLARITY];
		case (drv)
			PGM_DRV_PUSH_PULL: begin
				o_supply_ok_output = pin_level;
				o_supply_ok_oe = 1'b1;
			end
			PGM_DRV_OPEN_DRAIN: begin
				o_supply_ok_output = 1'b0;
				o_supply_ok_oe = !pin_level;
			end
			default: begin
				o_supply_ok_output = 1'b0;
				o_supply_ok_oe = 1'b0;
			end
		endcase
	end

	assign o_supply_ok_active = active_r;
	assign o_reg_rdata = rdata_r;
	assign o_otp_reload = soft_reset_r;
	assign o_serial_if_reset = soft_reset_r;

	property p_pin_polarity;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(o_supply_ok_oe && !src_ctrl_r[`PGM_BIT_DRIVER_TYPE]) |-> (o_supply_ok_output == (active_r ^ src_ctrl_r[7]));
	endproperty
	a_pin_polarity: assert property (p_pin_polarity) else $error("pin level disagrees with polarity");

	property p_open_drain;
		@(posedge i_sys_clk) disable iff (!rst_n)
		src_ctrl_r[`PGM_BIT_DRIVER_TYPE] |-> !o_supply_ok_output && (o_supply_ok_oe == !(active_r ^ src_ctrl_r[7]));
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain pin drove high");

	property p_none_monitored;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(src_ctrl_r[3:0] == 4'h0 && !mode_r[1] && !(mode_r[2] && twarn_s) && !soft_reset_r && !wr_src && !wr_mode)
		|=> active_r;
	endproperty
	a_none_monitored: assert property (p_none_monitored) else $error("output inactive with no source");

	property p_thermal;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(mode_r[`PGM_BIT_MON_THERMAL] && twarn_s) |=> !active_r;
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal warning did not drop output");

	property p_fault_gates;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(mode_r[`PGM_BIT_FAULT_SELECT] && fault_r != 4'h0) |=> !active_r;
	endproperty
	a_fault_gates: assert property (p_fault_gates) else $error("fault flag did not gate output");

	property p_fault_set;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(fault_set != 4'h0) |=> ((fault_r & $past(fault_set)) == $past(fault_set));
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("invalid source did not set fault");

	property p_clear_blocked;
		@(posedge i_sys_clk) disable iff (!rst_n)
		((clear_blocked & fault_r) != 4'h0) |=> ((fault_r & $past(clear_blocked & fault_r)) != 4'h0);
	endproperty
	a_clear_blocked: assert property (p_clear_blocked) else $error("fault cleared while source invalid");

	property p_soft_reset;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(wr_soft && i_reg_wdata[0] && !soft_reset_r) |=> (o_otp_reload && o_serial_if_reset)
		##1 (!soft_reset_r && src_ctrl_r == `PGM_SRC_CTRL_RST && mode_r == `PGM_MODE_CTRL_RST && rst_evt_r);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset sequence wrong");

	property p_lost_flag;
		@(posedge i_sys_clk) disable iff (!rst_n)
		$fell(active_r) |-> lost_r;
	endproperty
	a_lost_flag: assert property (p_lost_flag) else $error("loss of supply ok not latched");

	property p_reserved_zero;
		@(posedge i_sys_clk) disable iff (!rst_n)
		(i_reg_rd && i_reg_addr == `PGM_ADDR_MODE_CTRL) |=> (o_reg_rdata[7:3] == 5'h00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
endmodule : pgm_supply_ok_monitor

// ---- tb/pgm_host_model.sv ----
// host model driving the register byte port of the supply-ok monitor
`timescale 1ns/1ps
module pgm_host_model import pgm_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_reg_rdata,
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata
);
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
	end
	// request held until the taking edge, data scrambled after release
	task automatic wr(input pgm_byte_t a, input pgm_byte_t d);
		@(posedge i_sys_clk);
		o_reg_wr <= 1'b1;
		o_reg_addr <= a;
		o_reg_wdata <= d;
		@(posedge i_sys_clk);
		o_reg_wr <= 1'b0;
		o_reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input pgm_byte_t a, output pgm_byte_t d);
		@(posedge i_sys_clk);
		o_reg_rd <= 1'b1;
		o_reg_addr <= a;
		@(posedge i_sys_clk);
		o_reg_rd <= 1'b0;
		#1;
		d = i_reg_rdata;
	endtask : rd
endmodule : pgm_host_model

// ---- tb/test_pgm_supply_ok_monitor.sv ----
// self-checking bench for the supply-ok monitor
`timescale 1ns/1ps
`include "pgm_regs.svh"
module test_pgm_supply_ok_monitor import pgm_pkg::*;;
	localparam pgm_byte_t SRC = `PGM_ADDR_SRC_CTRL;
	localparam pgm_byte_t MOD = `PGM_ADDR_MODE_CTRL;
	localparam pgm_byte_t FLT = `PGM_ADDR_FAULT;
	localparam pgm_byte_t SRS = `PGM_ADDR_SOFT_RESET;
	localparam pgm_byte_t TOP = `PGM_ADDR_EVT_TOP;
	localparam pgm_byte_t EVR = `PGM_ADDR_EVT_RESET;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic reg_wr;
	logic reg_rd;
	logic tw = 1'b0;
	logic pin;
	logic oe;
	logic act;
	logic reload;
	logic sreset;
	pgm_byte_t addr;
	pgm_byte_t wdata;
	pgm_byte_t rdata;
	pgm_byte_t rv;
	pgm_src_t uv = 4'h0;
	pgm_src_t ov = 4'h0;
	pgm_src_t en = 4'hF;
	pgm_src_t src;
	pgm_byte_t ra[7] = '{SRC, MOD, FLT, SRS, TOP, EVR, 8'h20};
	pgm_byte_t rr[7] = '{8'h7F, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	int pulses = 0;
	always #20 sys_clk = ~sys_clk;
	pgm_supply_ok_monitor i_pgm_supply_ok_monitor (
		.i_sys_clk(sys_clk),
		.i_nrst(nrst),
		.i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd),
		.i_reg_addr(addr),
		.i_reg_wdata(wdata),
		.i_undervoltage(uv),
		.i_overvoltage(ov),
		.i_thermal_warning(tw),
		.i_regulator_enabled(en),
		.o_reg_rdata(rdata),
		.o_supply_ok_output(pin),
		.o_supply_ok_oe(oe),
		.o_supply_ok_active(act),
		.o_otp_reload(reload),
		.o_serial_if_reset(sreset)
	);
	pgm_host_model i_pgm_host_model (
		.i_sys_clk(sys_clk),
		.i_reg_rdata(rdata),
		.o_reg_wr(reg_wr),
		.o_reg_rd(reg_rd),
		.o_reg_addr(addr),
		.o_reg_wdata(wdata)
	);
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		pulses <= pulses + int'(reload === 1'b1) + int'(sreset === 1'b1);
		if (cyc == 4000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic check(input pgm_byte_t seen, input pgm_byte_t exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input pgm_byte_t a, input pgm_byte_t d);
		i_pgm_host_model.wr(a, d);
	endtask : wr
	task automatic rchk(input pgm_byte_t a, input pgm_byte_t exp);
		i_pgm_host_model.rd(a, rv);
		check(rv, exp);
	endtask : rchk
	// pin level is state xor polarity; open drain only pulls low
	// looked at one edge later, once the state flop has taken a register write
	task automatic pchk(input logic a, input logic pol, input logic od);
		logic lv;
		lv = a ^ pol;
		@(posedge sys_clk);
		#1;
		check({5'h00, act, pin, oe}, {5'h00, a, od ? 1'b0 : lv, od ? !lv : 1'b1});
	endtask : pchk
	// comparator inputs settle after the synchroniser and state flop
	task automatic drive(input pgm_src_t u, input pgm_src_t o, input logic t, input pgm_src_t e);
		@(posedge sys_clk);
		uv <= u;
		ov <= o;
		tw <= t;
		en <= e;
		repeat (5) @(posedge sys_clk);
	endtask : drive
	initial begin
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		foreach (ra[k]) rchk(ra[k], rr[k]);
		for (int k = 0; k < 4; k++) begin
			wr(SRC, {k[1:0], 6'h3F});
			pchk(1'b1, k[1], k[0]);
		end
		wr(SRC, 8'h7F);
		for (int i = 0; i < 4; i++) begin
			src = 4'h1 << i;
			drive(src, 4'h0, 1'b0, 4'hF);
			pchk(1'b0, 1'b0, 1'b1);
			rchk(FLT, {4'h0, src});
			wr(FLT, {4'h0, src});
			rchk(FLT, {4'h0, src});
			rchk(TOP, 8'h80);
			drive(4'h0, src, 1'b0, 4'hF);
			pchk(1'b0, 1'b0, 1'b1);
			wr(SRC, (i < 2) ? 8'h6F : 8'h5F);
			pchk(1'b1, 1'b0, 1'b1);
			wr(FLT, {4'h0, src});
			rchk(FLT, 8'h00);
			wr(SRC, 8'h7F & ~{4'h0, src});
			drive(src, 4'h0, 1'b0, 4'hF);
			pchk(1'b1, 1'b0, 1'b1);
			rchk(FLT, 8'h00);
			drive(4'h0, 4'h0, 1'b0, 4'hF);
			wr(SRC, 8'h7F);
			wr(TOP, 8'h80);
			rchk(TOP, 8'h00);
		end
		drive(4'h0, 4'h0, 1'b1, 4'hF);
		pchk(1'b0, 1'b0, 1'b1);
		wr(MOD, 8'hF8);
		pchk(1'b1, 1'b0, 1'b1);
		rchk(MOD, 8'h00);
		wr(MOD, 8'h06);
		drive(4'h1, 4'h0, 1'b0, 4'hF);
		drive(4'h0, 4'h0, 1'b0, 4'hF);
		pchk(1'b0, 1'b0, 1'b1);
		wr(FLT, 8'h01);
		pchk(1'b1, 1'b0, 1'b1);
		wr(MOD, 8'h04);
		drive(4'h1, 4'h0, 1'b0, 4'hE);
		pchk(1'b1, 1'b0, 1'b1);
		wr(MOD, 8'h05);
		pchk(1'b0, 1'b0, 1'b1);
		drive(4'h0, 4'h0, 1'b0, 4'hF);
		wr(SRC, 8'h80);
		wr(SRS, 8'h01);
		rchk(SRS, 8'h00);
		foreach (rr[k]) if (k < 5) rchk(ra[k], rr[k]);
		rchk(EVR, 8'h01);
		check(pulses[7:0], 8'h02);
		pchk(1'b1, 1'b0, 1'b1);
		wr(EVR, 8'h01);
		rchk(EVR, 8'h00);
		give_verdict();
	end
endmodule : test_pgm_supply_ok_monitor
